// ===== hw/ceb_defines.svh
`ifndef CEB_DEFINES_SVH
`define CEB_DEFINES_SVH

// Purpose: Shared constants of the external bus unit.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Pin widths are fixed; the refresh counter is one byte wide.

`define CEB_CLK_PERIOD_NS 10
`define CEB_ADDR_W 16
`define CEB_DATA_W 8
`define CEB_SYNC_W 32
`define CEB_STROBE_NS 30
`define CEB_STROBE_CYC ((`CEB_STROBE_NS + `CEB_CLK_PERIOD_NS - 1) / `CEB_CLK_PERIOD_NS)
`define CEB_REFRESH_MARKER_N_RESET 8'h00
`define CEB_REFRESH_MARKER_N_HIGH 8'h00
`define CEB_AUX_BIT 7
`define CEB_SYNC_RESET 32'hFFFF_FFFF

`endif

// ===== hw/ceb_pkg.sv
// Purpose: Types of the external bus unit.
// Assumes: Constants come from ceb_defines.svh.
// Notes: States are one-hot with the codes written out.

package ceb_pkg;

    typedef enum logic [6:0] {
        CEB_IDLE    = 7'h01,
        CEB_ADDR    = 7'h02,
        CEB_STROBE  = 7'h04,
        CEB_REFRESH = 7'h08,
        CEB_FLOAT   = 7'h10,
        CEB_GRANT   = 7'h20,
        CEB_RELEASE = 7'h40
    } ceb_state_e;

    typedef enum logic [2:0] {
        CEB_FETCH   = 3'h0,
        CEB_MEM_RD  = 3'h1,
        CEB_MEM_WR  = 3'h2,
        CEB_IO_RD   = 3'h3,
        CEB_IO_WR   = 3'h4,
        CEB_INT_ACK = 3'h5
    } ceb_kind_e;

    typedef struct packed {
        ceb_state_e state;
        ceb_kind_e kind;
        logic onchip;
        logic [1:0] cnt;
        logic [15:0] addr;
        logic [15:0] addr_pin;
        logic addr_oe_n;
        logic [7:0] wdata;
        logic [7:0] data_pin;
        logic data_oe_n;
        logic rd_n;
        logic wr_n;
        logic memory_request_n;
        logic io_request_n;
        logic strobe_oe_n;
        logic first_cycle_marker_n;
        logic first_cycle_oe_n;
        logic refresh_marker_n;
        logic aux_address_bit;
        logic [7:0] refresh_marker_n_addr;
        logic bus_grant_ack_n;
        logic halt_n;
        logic irq_oe_n;
        logic nmi_prev;
        logic nmi_pending;
        logic take_nmi;
        logic take_int;
        logic done;
        logic [7:0] rdata;
        logic ext_rd_prev;
        logic ext_wr_prev;
        logic ext_rd;
        logic ext_wr;
        logic [15:0] ext_addr;
        logic [7:0] ext_wdata;
    } ceb_state_s;

endpackage : ceb_pkg

// ===== hw/ceb_pin_sync.sv
// Purpose: Two-flop synchroniser for every pin that the bus unit reads.
// Assumes: Pins idle high; reset loads the idle level.
// Notes: Only the second stage leaves this module.

`timescale 1ns/1ps

`include "ceb_defines.svh"

module ceb_pin_sync (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Pins and synchronised copy
    input wire logic [`CEB_SYNC_W-1:0] pins_i,
    output logic [`CEB_SYNC_W-1:0] pins_o
);

    logic [`CEB_SYNC_W-1:0] stage1;

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            stage1 <= `CEB_SYNC_RESET;
            pins_o <= `CEB_SYNC_RESET;
        end
        else
        begin
            stage1 <= pins_i;
            pins_o <= stage1;
        end
    end

endmodule : ceb_pin_sync

// ===== hw/ceb_bus_unit.sv
// Purpose: External bus signalling of an 8-bit controller core.
// Assumes: The core issues one bus request at a time and waits for done.
// Notes: Pins are split into input, output and active-low output enable.

`timescale 1ns/1ps

`include "ceb_defines.svh"

module ceb_bus_unit (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Core request side
    input wire logic req_i,
    input wire ceb_pkg::ceb_kind_e req_kind_i,
    input wire logic req_onchip_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    // Core status and interrupt side
    input wire logic halted_i,
    input wire logic int_enable_i,
    input wire logic sample_irq_i,
    output logic take_nmi_o,
    output logic take_int_o,
    // On-chip peripherals
    input wire logic periph_irq_i,
    input wire logic [7:0] periph_rdata_i,
    output logic ext_periph_rd_o,
    output logic ext_periph_wr_o,
    output logic [15:0] ext_periph_addr_o,
    output logic [7:0] ext_periph_wdata_o,
    // Address and data pins
    input wire logic [15:0] addr_i,
    output logic [15:0] addr_o,
    output logic addr_oe_n_o,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    // Strobe pins, all sharing one enable
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic memory_request_n_i,
    input wire logic io_request_n_i,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic memory_request_n_o,
    output logic io_request_n_o,
    output logic strobe_oe_n_o,
    // Cycle markers and status pins
    output logic first_cycle_marker_n_o,
    output logic first_cycle_marker_oe_n_o,
    output logic refresh_marker_n_o,
    output logic aux_address_bit_o,
    output logic halt_n_o,
    // Interrupt pins
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_oe_n_o,
    input wire logic nonmaskable_irq_n_i,
    // Bus grant and mode pins
    input wire logic bus_grant_request_n_i,
    output logic bus_grant_ack_n_o,
    input wire logic emulation_mode_i
);

    import ceb_pkg::*;

    ceb_state_s s;
    ceb_state_s next_s;
    logic [`CEB_SYNC_W-1:0] sync;
    logic [15:0] ext_addr;
    logic [7:0] ext_data;
    logic ext_rd_n;
    logic ext_wr_n;
    logic ext_mem_n;
    logic ext_io_n;
    logic grant_req_n;
    logic nmi_n;
    logic irq_n;
    logic emul;

    // Emulation mode is a strap, but it arrives as a pin.
    ceb_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pins_i({addr_i, data_i, rd_n_i, wr_n_i, memory_request_n_i, io_request_n_i,
                 bus_grant_request_n_i, nonmaskable_irq_n_i, irq_n_i, ~emulation_mode_i}),
        .pins_o(sync)
    );

    assign ext_addr = sync[31:16];
    assign ext_data = sync[15:8];
    assign ext_rd_n = sync[7];
    assign ext_wr_n = sync[6];
    assign ext_mem_n = sync[5];
    assign ext_io_n = sync[4];
    assign grant_req_n = sync[3];
    assign nmi_n = sync[2];
    assign irq_n = sync[1];
    assign emul = ~sync[0];

    function automatic logic is_mem(input ceb_kind_e k);
        is_mem = (k == CEB_FETCH) || (k == CEB_MEM_RD) || (k == CEB_MEM_WR);
    endfunction : is_mem

    function automatic logic is_write(input ceb_kind_e k);
        is_write = (k == CEB_MEM_WR) || (k == CEB_IO_WR);
    endfunction : is_write

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.take_nmi = 1'b0;
        next_s.take_int = 1'b0;
        next_s.ext_rd = 1'b0;
        next_s.ext_wr = 1'b0;
        next_s.halt_n = ~halted_i;
        next_s.irq_oe_n = ~periph_irq_i;
        next_s.first_cycle_oe_n = emul;
        next_s.aux_address_bit = s.addr_pin[`CEB_AUX_BIT];

        // A non-maskable edge is held until the core samples it.
        next_s.nmi_prev = nmi_n;
        if (sample_irq_i)
        begin
            if (s.nmi_pending)
            begin
                next_s.take_nmi = 1'b1;
                next_s.nmi_pending = 1'b0;
            end
            else if (!irq_n && int_enable_i)
            begin
                next_s.take_int = 1'b1;
            end
        end
        if (s.nmi_prev && !nmi_n)
        begin
            next_s.nmi_pending = 1'b1;
        end

        case (s.state)
            CEB_IDLE:
            begin
                if (!grant_req_n)
                begin
                    // Float first; acknowledge follows one cycle later.
                    next_s.addr_oe_n = 1'b1;
                    next_s.data_oe_n = 1'b1;
                    next_s.strobe_oe_n = 1'b1;
                    next_s.state = CEB_FLOAT;
                end
                else if (req_i)
                begin
                    next_s.kind = req_kind_i;
                    next_s.onchip = req_onchip_i;
                    next_s.addr = req_addr_i;
                    next_s.wdata = req_wdata_i;
                    next_s.addr_pin = req_addr_i;
                    next_s.aux_address_bit = req_addr_i[`CEB_AUX_BIT];
                    next_s.addr_oe_n = 1'b0;
                    next_s.first_cycle_marker_n =
                        ~((req_kind_i == CEB_FETCH) || (req_kind_i == CEB_INT_ACK));
                    if (is_write(req_kind_i))
                    begin
                        next_s.data_pin = req_wdata_i;
                        next_s.data_oe_n = 1'b0;
                    end
                    next_s.state = CEB_ADDR;
                end
            end
            CEB_ADDR:
            begin
                next_s.cnt = 2'(`CEB_STROBE_CYC - 1);
                if (is_mem(s.kind))
                begin
                    next_s.memory_request_n = 1'b0;
                end
                else
                begin
                    next_s.io_request_n = 1'b0;
                end
                if (is_write(s.kind))
                begin
                    next_s.wr_n = 1'b0;
                end
                else if (s.kind != CEB_INT_ACK)
                begin
                    next_s.rd_n = 1'b0;
                end
                if (s.onchip && !is_write(s.kind))
                begin
                    next_s.data_pin = periph_rdata_i;
                    next_s.data_oe_n = 1'b0;
                end
                next_s.state = CEB_STROBE;
            end
            CEB_STROBE:
            begin
                if (s.onchip && !is_write(s.kind))
                begin
                    next_s.data_pin = periph_rdata_i;
                end
                if (s.cnt != 2'h0)
                begin
                    next_s.cnt = s.cnt - 2'h1;
                end
                else
                begin
                    next_s.rdata = s.onchip ? periph_rdata_i : ext_data;
                    next_s.done = 1'b1;
                    next_s.rd_n = 1'b1;
                    next_s.wr_n = 1'b1;
                    next_s.memory_request_n = 1'b1;
                    next_s.io_request_n = 1'b1;
                    next_s.first_cycle_marker_n = 1'b1;
                    next_s.data_oe_n = 1'b1;
                    next_s.state = CEB_IDLE;
                    if (s.kind == CEB_FETCH)
                    begin
                        // Opcode fetch is followed by one refresh cycle.
                        next_s.addr_pin = {`CEB_REFRESH_MARKER_N_HIGH, s.refresh_marker_n_addr};
                        next_s.aux_address_bit = s.refresh_marker_n_addr[`CEB_AUX_BIT];
                        next_s.memory_request_n = 1'b0;
                        next_s.refresh_marker_n = 1'b0;
                        next_s.state = CEB_REFRESH;
                    end
                end
            end
            CEB_REFRESH:
            begin
                next_s.aux_address_bit = s.refresh_marker_n_addr[`CEB_AUX_BIT];
                next_s.memory_request_n = 1'b1;
                next_s.refresh_marker_n = 1'b1;
                next_s.refresh_marker_n_addr = s.refresh_marker_n_addr + 8'h01;
                next_s.state = CEB_IDLE;
            end
            CEB_FLOAT:
            begin
                // Pins have been released for a full cycle now.
                next_s.bus_grant_ack_n = 1'b0;
                next_s.ext_rd_prev = 1'b1;
                next_s.ext_wr_prev = 1'b1;
                next_s.state = CEB_GRANT;
            end
            CEB_GRANT:
            begin
                // The master owns the address and strobes; we listen, and drive data only on its I/O reads.
                next_s.ext_rd_prev = ext_rd_n;
                next_s.ext_wr_prev = ext_wr_n;
                next_s.ext_addr = ext_addr;
                if (!ext_io_n && s.ext_rd_prev && !ext_rd_n)
                begin
                    next_s.ext_rd = 1'b1;
                end
                if (!ext_io_n && s.ext_wr_prev && !ext_wr_n)
                begin
                    next_s.ext_wr = 1'b1;
                    next_s.ext_wdata = ext_data;
                end
                // Memory cycles of the master are not ours to answer.
                next_s.data_oe_n = ~(!ext_io_n && ext_mem_n && !ext_rd_n);
                next_s.data_pin = periph_rdata_i;
                if (grant_req_n)
                begin
                    next_s.bus_grant_ack_n = 1'b1;
                    next_s.data_oe_n = 1'b1;
                    next_s.state = CEB_RELEASE;
                end
            end
            CEB_RELEASE:
            begin
                // One idle cycle so the master's drivers are gone first.
                next_s.rd_n = 1'b1;
                next_s.wr_n = 1'b1;
                next_s.memory_request_n = 1'b1;
                next_s.io_request_n = 1'b1;
                next_s.strobe_oe_n = 1'b0;
                next_s.state = CEB_IDLE;
            end
            default:
            begin
                next_s.state = CEB_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            s <= '0;
            s.state <= CEB_IDLE;
            s.kind <= CEB_FETCH;
            s.rd_n <= 1'b1;
            s.wr_n <= 1'b1;
            s.memory_request_n <= 1'b1;
            s.io_request_n <= 1'b1;
            s.first_cycle_marker_n <= 1'b1;
            s.first_cycle_oe_n <= 1'b0;
            s.refresh_marker_n <= 1'b1;
            s.data_oe_n <= 1'b1;
            s.bus_grant_ack_n <= 1'b1;
            s.halt_n <= 1'b1;
            s.irq_oe_n <= 1'b1;
            s.nmi_prev <= 1'b1;
            s.ext_rd_prev <= 1'b1;
            s.ext_wr_prev <= 1'b1;
            s.refresh_marker_n_addr <= `CEB_REFRESH_MARKER_N_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign done_o = s.done;
    assign rdata_o = s.rdata;
    assign take_nmi_o = s.take_nmi;
    assign take_int_o = s.take_int;
    assign ext_periph_rd_o = s.ext_rd;
    assign ext_periph_wr_o = s.ext_wr;
    assign ext_periph_addr_o = s.ext_addr;
    assign ext_periph_wdata_o = s.ext_wdata;
    assign addr_o = s.addr_pin;
    assign addr_oe_n_o = s.addr_oe_n;
    assign data_o = s.data_pin;
    assign data_oe_n_o = s.data_oe_n;
    assign rd_n_o = s.rd_n;
    assign wr_n_o = s.wr_n;
    assign memory_request_n_o = s.memory_request_n;
    assign io_request_n_o = s.io_request_n;
    assign strobe_oe_n_o = s.strobe_oe_n;
    assign first_cycle_marker_n_o = s.first_cycle_marker_n;
    assign first_cycle_marker_oe_n_o = s.first_cycle_oe_n;
    assign refresh_marker_n_o = s.refresh_marker_n;
    assign aux_address_bit_o = s.aux_address_bit;
    assign halt_n_o = s.halt_n;
    // The open-drain pin only ever pulls low.
    assign irq_n_o = 1'b0;
    assign irq_oe_n_o = s.irq_oe_n;
    assign bus_grant_ack_n_o = s.bus_grant_ack_n;

endmodule : ceb_bus_unit

// ===== testbench/ceb_bus_sva.sv
// Purpose: Concurrent checks on the pins of the external bus unit.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound onto every instance of the bus unit.

`timescale 1ns/1ps

module ceb_bus_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Core and interrupt side
    input wire logic halted_i,
    input wire logic int_enable_i,
    input wire logic sample_irq_i,
    input wire logic take_nmi_o,
    input wire logic take_int_o,
    input wire logic periph_irq_i,
    input wire logic irq_oe_n_o,
    // Bus pins
    input wire logic [15:0] addr_o,
    input wire logic addr_oe_n_o,
    input wire logic data_oe_n_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic memory_request_n_o,
    input wire logic io_request_n_o,
    input wire logic strobe_oe_n_o,
    // Markers, status and mode
    input wire logic first_cycle_marker_n_o,
    input wire logic first_cycle_marker_oe_n_o,
    input wire logic refresh_marker_n_o,
    input wire logic aux_address_bit_o,
    input wire logic halt_n_o,
    input wire logic bus_grant_ack_n_o,
    input wire logic emulation_mode_i
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    logic refresh_marker_n_q;
    logic seen_r;
    logic [7:0] last_r;

    // The first refresh only arms the step check.
    always_ff @(posedge sys_clk_i)
    begin
        refresh_marker_n_q <= refresh_marker_n_o;
        if (srst_i)
        begin
            seen_r <= 1'b0;
            last_r <= 8'h00;
        end
        else if (!refresh_marker_n_o && refresh_marker_n_q)
        begin
            seen_r <= 1'b1;
            last_r <= addr_o[7:0];
        end
    end

    property p_refresh_marker_n_addr;
        !refresh_marker_n_o |-> !memory_request_n_o && !addr_oe_n_o && addr_o[15:8] == 8'h00;
    endproperty
    a_refresh_marker_n_addr: assert property (p_refresh_marker_n_addr) else $error("refresh");
    property p_refresh_marker_n_step;
        !refresh_marker_n_o && refresh_marker_n_q && seen_r |-> addr_o[7:0] == last_r + 8'h01;
    endproperty
    a_refresh_marker_n_step: assert property (p_refresh_marker_n_step) else $error("refresh step");
    property p_aux_bit;
        !addr_oe_n_o |-> aux_address_bit_o == addr_o[7];
    endproperty
    a_aux_bit: assert property (p_aux_bit) else $error("aux bit");
    property p_fetch;
        $fell(first_cycle_marker_n_o) ##1 io_request_n_o |-> (!memory_request_n_o && !rd_n_o)[*3];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch");
    property p_int_ack;
        $fell(first_cycle_marker_n_o) ##1 !io_request_n_o
            |-> (memory_request_n_o && rd_n_o && !first_cycle_marker_n_o)[*3];
    endproperty
    a_int_ack: assert property (p_int_ack) else $error("acknowledge");
    property p_io_addr;
        !io_request_n_o && !strobe_oe_n_o |-> memory_request_n_o && !addr_oe_n_o;
    endproperty
    a_io_addr: assert property (p_io_addr) else $error("io request");
    property p_memory_request_n;
        !memory_request_n_o && !strobe_oe_n_o |-> !addr_oe_n_o && io_request_n_o;
    endproperty
    a_memory_request_n: assert property (p_memory_request_n) else $error("memory request");
    property p_write;
        !wr_n_o && !strobe_oe_n_o |-> !data_oe_n_o && rd_n_o;
    endproperty
    a_write: assert property (p_write) else $error("write");
    property p_float;
        !bus_grant_ack_n_o |-> addr_oe_n_o && strobe_oe_n_o;
    endproperty
    a_float: assert property (p_float) else $error("float");
    property p_ack_late;
        $fell(bus_grant_ack_n_o) |-> $past(addr_oe_n_o) && $past(strobe_oe_n_o) && $past(data_oe_n_o);
    endproperty
    a_ack_late: assert property (p_ack_late) else $error("grant early");
    property p_int_gate;
        take_int_o |-> $past(sample_irq_i) && $past(int_enable_i) && !take_nmi_o;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("maskable");
    property p_halt;
        halted_i[*2] |-> !halt_n_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_irq_pin;
        periph_irq_i[*2] |-> !irq_oe_n_o;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq pin");
    property p_emul;
        emulation_mode_i[*4] |-> first_cycle_marker_oe_n_o;
    endproperty
    a_emul: assert property (p_emul) else $error("emulation");

    c_refresh: cover property ($fell(refresh_marker_n_o));
    c_grant: cover property ($fell(bus_grant_ack_n_o));
    c_int: cover property (take_int_o);
endmodule : ceb_bus_sva

bind ceb_bus_unit ceb_bus_sva i_sva (.*);

// ===== testbench/ceb_far_model.sv
// Purpose: Memory, I/O space and an external master on the far side of the bus.
// Assumes: Strobes and interrupt pins have pull-ups; data and address do not.
// Notes: Undriven data and address toggle so stale values never pass.

`timescale 1ns/1ps

module ceb_far_model #(parameter logic [7:0] VECTOR = 8'h5A) (
    // Clock
    input wire logic sys_clk_i,
    // Device side of the pins
    input wire logic [15:0] addr_o,
    input wire logic addr_oe_n_o,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic memory_request_n_o,
    input wire logic io_request_n_o,
    input wire logic strobe_oe_n_o,
    input wire logic first_cycle_marker_n_o,
    input wire logic irq_n_o,
    input wire logic irq_oe_n_o,
    // Resolved pin levels
    output logic [15:0] addr_i,
    output logic [7:0] data_i,
    output logic rd_n_i,
    output logic wr_n_i,
    output logic memory_request_n_i,
    output logic io_request_n_i,
    output logic irq_n_i
);
    logic [7:0] mem [0:65535];
    logic [7:0] io [0:255];
    logic [7:0] last_d = 8'h00;
    logic [15:0] last_a = 16'h0000;
    logic m_on = 1'b0;
    logic m_wr_n = 1'b1;
    logic m_io_n = 1'b1;
    logic [15:0] m_addr = 16'h0000;
    logic [7:0] m_data = 8'h00;
    wire logic dev_rd = !strobe_oe_n_o && !rd_n_o;
    wire logic ack = !strobe_oe_n_o && !io_request_n_o && !first_cycle_marker_n_o;

    assign data_i = !data_oe_n_o ? data_o : ack ? VECTOR :
        dev_rd && !memory_request_n_o ? mem[addr_o] : dev_rd && !io_request_n_o ? io[addr_o[7:0]] :
        m_on && !m_wr_n ? m_data : ~last_d;
    assign addr_i = !addr_oe_n_o ? addr_o : m_on ? m_addr : ~last_a;
    assign rd_n_i = strobe_oe_n_o ? 1'b1 : rd_n_o;
    assign wr_n_i = strobe_oe_n_o ? !m_on || m_wr_n : wr_n_o;
    assign memory_request_n_i = strobe_oe_n_o ? 1'b1 : memory_request_n_o;
    assign io_request_n_i = strobe_oe_n_o ? !m_on || m_io_n : io_request_n_o;
    assign irq_n_i = irq_oe_n_o || irq_n_o;

    always @(posedge sys_clk_i)
    begin
        last_d <= data_i;
        last_a <= addr_i;
        if (!strobe_oe_n_o && !wr_n_o && !memory_request_n_o)
            mem[addr_o] <= data_i;
        if (!strobe_oe_n_o && !wr_n_o && !io_request_n_o)
            io[addr_o[7:0]] <= data_i;
    end

    // Address settles two edges before the strobe falls.
    task automatic master_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        m_on <= 1'b1;
        m_addr <= a;
        m_data <= d;
        m_io_n <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        m_wr_n <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        m_wr_n <= 1'b1;
        @(posedge sys_clk_i);
        m_io_n <= 1'b1;
        m_on <= 1'b0;
    endtask : master_write
endmodule : ceb_far_model

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the external bus unit.
// Assumes: Far side is the memory, I/O and master model.
// Notes: Expected memory and I/O read data comes from bench arrays.

`timescale 1ns/1ps

module tb_top;
    import ceb_pkg::*;
    localparam logic [7:0] VECTOR = 8'hC3;
    localparam int LIMIT = 4000;
    logic sys_clk_i, srst_i, req_i, req_onchip_i, done_o, halted_i, int_enable_i, sample_irq_i;
    logic take_nmi_o, take_int_o, periph_irq_i, ext_periph_rd_o, ext_periph_wr_o, addr_oe_n_o;
    logic data_oe_n_o, rd_n_i, wr_n_i, memory_request_n_i, io_request_n_i, rd_n_o, wr_n_o;
    logic memory_request_n_o, io_request_n_o, strobe_oe_n_o, first_cycle_marker_n_o;
    logic first_cycle_marker_oe_n_o, refresh_marker_n_o, aux_address_bit_o, halt_n_o, irq_n_i;
    logic irq_n_o, irq_oe_n_o, nonmaskable_irq_n_i, bus_grant_request_n_i, bus_grant_ack_n_o;
    logic emulation_mode_i, wr_seen = 1'b0;
    logic [15:0] req_addr_i, ext_periph_addr_o, addr_i, addr_o, a, a_seen;
    logic [7:0] req_wdata_i, rdata_o, periph_rdata_i, ext_periph_wdata_o, data_i, data_o, d, d_seen;
    ceb_kind_e req_kind_i;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'h13f6_39a6;
    int i;
    logic [7:0] mem_m [int];
    logic [7:0] io_m [int];
    int addrs [$];

    ceb_bus_unit i_dut (.*);
    ceb_far_model #(.VECTOR(VECTOR)) i_far (.*);

    always #5 sys_clk_i = ~sys_clk_i;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (ext_periph_wr_o === 1'b1)
        begin
            wr_seen <= 1'b1;
            a_seen <= ext_periph_addr_o;
            d_seen <= ext_periph_wdata_o;
        end
        if (cycles == LIMIT)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic bus(input ceb_kind_e k, input logic [15:0] ad, input logic [7:0] wd, input logic oc);
        int n;
        @(posedge sys_clk_i);
        req_i <= 1'b1;
        req_kind_i <= k;
        req_addr_i <= ad;
        req_wdata_i <= wd;
        req_onchip_i <= oc;
        @(posedge sys_clk_i);
        req_i <= 1'b0;
        for (n = 0; n < 10; n++)
        begin
            @(posedge sys_clk_i);
            #1;
            if (done_o === 1'b1)
                break;
        end
        check(done_o, 1'b1, "done");
        repeat (2) @(posedge sys_clk_i);
    endtask : bus

    task automatic wait_ack(input logic lvl);
        int n;
        for (n = 0; n < 12 && bus_grant_ack_n_o !== lvl; n++)
            @(posedge sys_clk_i);
        #1;
    endtask : wait_ack

    task automatic irq(input logic exp_nmi, input logic exp_int);
        @(posedge sys_clk_i);
        sample_irq_i <= 1'b1;
        @(posedge sys_clk_i);
        sample_irq_i <= 1'b0;
        #1;
        check(take_nmi_o, exp_nmi, "nmi");
        check(take_int_o, exp_int, "int");
    endtask : irq

    initial
    begin
        {sys_clk_i, req_i, req_onchip_i, halted_i, int_enable_i, sample_irq_i} = 6'h00;
        {periph_irq_i, emulation_mode_i, req_addr_i, req_wdata_i} = 26'h0;
        {srst_i, nonmaskable_irq_n_i, bus_grant_request_n_i} = 3'h7;
        req_kind_i = CEB_FETCH;
        periph_rdata_i = 8'h00;
        repeat (4) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        for (i = 0; i < 6; i++)
        begin
            a = $random(seed);
            d = $random(seed);
            mem_m[a] = d;
            addrs.push_back(a);
            bus(CEB_MEM_WR, a, d, 1'b0);
        end
        while (addrs.size() > 0)
        begin
            a = addrs.pop_back();
            bus(addrs.size() % 2 ? CEB_FETCH : CEB_MEM_RD, a, 8'h00, 1'b0);
            check(rdata_o, mem_m[a], "mem rd");
        end
        for (i = 0; i < 3; i++)
        begin
            a = $random(seed);
            d = $random(seed);
            io_m[a[7:0]] = d;
            bus(CEB_IO_WR, a, d, 1'b0);
            bus(CEB_IO_RD, a ^ 16'hFF00, 8'h00, 1'b0);
            check(rdata_o, io_m[a[7:0]], "io read");
        end
        bus(CEB_INT_ACK, 16'h0000, 8'h00, 1'b0);
        check(rdata_o, VECTOR, "vector");
        d = $random(seed);
        periph_rdata_i <= d;
        bus(CEB_IO_RD, 16'h0042, 8'h00, 1'b1);
        check(rdata_o, d, "on-chip read");
        periph_irq_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        #1;
        check(irq_n_i, 1'b0, "irq pin");
        irq(1'b0, 1'b0);
        int_enable_i <= 1'b1;
        irq(1'b0, 1'b1);
        for (i = 1; i >= 0; i--)
        begin
            @(posedge sys_clk_i);
            int_enable_i <= i[0];
            nonmaskable_irq_n_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            nonmaskable_irq_n_i <= 1'b1;
            irq(1'b1, 1'b0);
        end
        periph_irq_i <= 1'b0;
        @(posedge sys_clk_i);
        halted_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check(halt_n_o, 1'b0, "halt");
        for (i = 1; i >= 0; i--)
        begin
            @(posedge sys_clk_i);
            emulation_mode_i <= i[0];
            repeat (4) @(posedge sys_clk_i);
            #1;
            check(first_cycle_marker_oe_n_o, i[0], "marker float");
        end
        @(posedge sys_clk_i);
        bus_grant_request_n_i <= 1'b0;
        wait_ack(1'b0);
        check({bus_grant_ack_n_o, addr_oe_n_o, strobe_oe_n_o}, 3'b011, "grant");
        a = $random(seed);
        d = $random(seed);
        i_far.master_write(a, d);
        repeat (3) @(posedge sys_clk_i);
        check({wr_seen, d_seen}, {1'b1, d}, "master write");
        check(a_seen, a, "master addr");
        bus_grant_request_n_i <= 1'b1;
        wait_ack(1'b1);
        check(bus_grant_ack_n_o, 1'b1, "release");
        summarize();
    end
endmodule : tb_top
